//--- core/sai_pkg.sv
// package with constants of the status and attention inputs
// Operation
// R01: status bit reads 0 when its positive conductor is high.
// R02: status lines reach software only, never steering transfers or handshakes.
// R03: qualifying attention transition sets a readable attention-request flag.
// R04: set flag raises the interrupt only when software enables forwarding.
// R05: attention acts only when positive falls and negative rises; levels ignored.
// R06: grounded test input keeps data drivers enabled regardless of direction.
// R07: test input reads as status bit 1 when grounded.
// R08: channel adapter forwards attention to processor only with its enable.
// R09: two low status bits update on each sync strobe rising edge.
// R10: third status receiver enabled only while direction is input.
// R11: attention input synchronised first so one transition gives one request.
package sai_pkg;

  localparam int SAI_ADDR_W = 8;
  localparam int SAI_DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] SAI_OFS_STATUS   = 8'h00;
  localparam logic [7:0] SAI_OFS_INT_STAT = 8'h04;
  localparam logic [7:0] SAI_OFS_INT_CLR  = 8'h08;
  localparam logic [7:0] SAI_OFS_INT_EN   = 8'h0c;

  // status register field positions
  localparam int SAI_BIT_STS0 = 0;
  localparam int SAI_BIT_STS1 = 1;
  localparam int SAI_BIT_STS2 = 2;
  localparam int SAI_BIT_HOOD = 3;
  localparam int SAI_BIT_ATTENTION_LINE = 4;
  localparam int SAI_BIT_DIR  = 5;

  // interrupt register field position
  localparam int SAI_BIT_INT_ATTENTION_LINE = 0;

  // values after reset, and the output direction value
  localparam logic [1:0] SAI_RST_STS      = 2'h0;
  localparam logic       SAI_RST_FLAG     = 1'b0;
  localparam logic       SAI_RST_EN       = 1'b0;
  localparam logic [1:0] SAI_RST_ATTENTION_LINE     = 2'h0;
  localparam logic       SAI_DIR_OUTPUT   = 1'b1;

  // synchroniser depth
  localparam int SAI_SYNC_STAGES = 2;

endpackage : sai_pkg

//--- core/sai_sync_if.sv
// interface carrying a raw level and its synchronised copy
`timescale 1ns/1ps
interface sai_sync_if #(
  parameter int WIDTH = 2
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;

  modport src (output raw,    input  synced);
  modport dst (input  raw,    output synced);
endinterface : sai_sync_if

//--- core/sai_sync2.sv
// two-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
module sai_sync2
  import sai_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input  wire logic clk,
  input  wire logic rst,
  sai_sync_if.dst   sif
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= sif.raw;
      sync_q <= meta_q;
    end
  end

  assign sif.synced = sync_q;

endmodule // sai_sync2

//--- core/sai_top.sv
// status and attention inputs of the parallel interface card
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module sai_top
  import sai_pkg::*;
(
  input  wire logic                  CLK_SYS,
  input  wire logic                  RESET,
  input  wire logic [2:0]            EXTERNAL_STATUS_IN,
  input  wire logic                  ATTENTION_LINE_P,
  input  wire logic                  ATTENTION_LINE_N,
  input  wire logic                  TEST_N,
  input  wire logic                  SYNC_N,
  input  wire logic                  TRANSFER_DIRECTION,
  input  wire logic [SAI_ADDR_W-1:0] ADDR,
  input  wire logic [SAI_DATA_W-1:0] WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output logic      [SAI_DATA_W-1:0] RDATA,
  output logic                       ATTENTION_LINE_IRQ,
  output logic                       DATA_DRV_EN,
  output logic                       STS2_RCV_EN
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [1:0] sts_q;
  logic       sts2_q;
  logic       hood_q;
  logic       sync_prev_q;
  logic       sync_rise;
  logic [1:0] attention_line_sync;
  logic [1:0] attention_line_prev_q;
  logic       attention_line_edge;
  logic       flag_q;
  logic       flag_d;
  logic       en_q;
  logic       clr_hit;
  logic [SAI_DATA_W-1:0] rdata_d;
  logic [SAI_DATA_W-1:0] status_word;

  ////////////////////////////////////////////////////////////////////////////
  // attention synchroniser

  sai_sync_if #(.WIDTH(2)) attention_line_if ();

  // both conductors crossed together so their edges stay aligned
  assign attention_line_if.raw = {ATTENTION_LINE_P, ATTENTION_LINE_N}; // [R11]
  assign attention_line_sync   = attention_line_if.synced;

  sai_sync2 #(
    .WIDTH (2)
  ) u_attention_line_sync (
    .clk (CLK_SYS),
    .rst (RESET),
    .sif (attention_line_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status sampling

  // sync strobe is active low; its release is the rising edge
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      sync_prev_q <= 1'b1;
    end else begin
      sync_prev_q <= SYNC_N;
    end
  end

  assign sync_rise = SYNC_N & ~sync_prev_q;

  // low status bits held between strobes, stored inverted
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      sts_q <= SAI_RST_STS;
    end else if (sync_rise) begin // [R09]
      sts_q <= ~EXTERNAL_STATUS_IN[1:0]; // [R01]
    end
  end

  // third status bit only meaningful while receiving
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      sts2_q <= 1'b0;
    end else if (TRANSFER_DIRECTION != SAI_DIR_OUTPUT) begin // [R10]
      sts2_q <= ~EXTERNAL_STATUS_IN[2]; // [R01]
    end else begin
      sts2_q <= 1'b0;
    end
  end

  // receiver enable follows direction; output shuts it off
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      STS2_RCV_EN <= 1'b0;
    end else begin
      STS2_RCV_EN <= (TRANSFER_DIRECTION != SAI_DIR_OUTPUT); // [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // test hood and driver enable

  // grounded test pin reads as one
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      hood_q <= 1'b0;
    end else begin
      hood_q <= ~TEST_N; // [R07]
    end
  end

  // status inputs deliberately absent here so they cannot steer drivers
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      DATA_DRV_EN <= 1'b0;
    end else begin
      DATA_DRV_EN <= (TRANSFER_DIRECTION == SAI_DIR_OUTPUT) | ~TEST_N; // [R06] [R02]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // attention edge detection

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      attention_line_prev_q <= SAI_RST_ATTENTION_LINE;
    end else begin
      attention_line_prev_q <= attention_line_sync;
    end
  end

  // positive conductor falls while negative rises; steady levels do nothing
  assign attention_line_edge = attention_line_prev_q[1] & ~attention_line_prev_q[0]
                   & ~attention_line_sync[1] & attention_line_sync[0]; // [R05]

  ////////////////////////////////////////////////////////////////////////////
  // attention flag, enable, interrupt

  assign clr_hit = WR & (ADDR == SAI_OFS_INT_CLR) & WDATA[SAI_BIT_INT_ATTENTION_LINE];

  // a new edge beats a clear in the same cycle
  always_comb begin
    flag_d = flag_q;
    if (clr_hit) begin
      flag_d = 1'b0;
    end
    if (attention_line_edge) begin
      flag_d = 1'b1; // [R03]
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      flag_q <= SAI_RST_FLAG;
    end else begin
      flag_q <= flag_d;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      en_q <= SAI_RST_EN;
    end else if (WR && ADDR == SAI_OFS_INT_EN) begin
      en_q <= WDATA[SAI_BIT_INT_ATTENTION_LINE];
    end
  end

  // level interrupt; flag alone never reaches the adapter
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ATTENTION_LINE_IRQ <= 1'b0;
    end else begin
      ATTENTION_LINE_IRQ <= flag_q & en_q; // [R04]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port

  // only sense and sampled state; nothing here feeds back into the card
  always_comb begin
    status_word               = '0;
    status_word[SAI_BIT_STS0] = sts_q[0]; // [R02]
    status_word[SAI_BIT_STS1] = sts_q[1];
    status_word[SAI_BIT_STS2] = sts2_q;
    status_word[SAI_BIT_HOOD] = hood_q; // [R07]
    status_word[SAI_BIT_ATTENTION_LINE] = flag_q; // [R03]
    status_word[SAI_BIT_DIR]  = TRANSFER_DIRECTION;
  end

  always_comb begin
    rdata_d = '0;
    if (RD) begin
      case (ADDR)
        SAI_OFS_STATUS:   rdata_d = status_word;
        SAI_OFS_INT_STAT: rdata_d[SAI_BIT_INT_ATTENTION_LINE] = flag_q;
        SAI_OFS_INT_EN:   rdata_d[SAI_BIT_INT_ATTENTION_LINE] = en_q;
        default:          rdata_d = '0; // clear register and holes read zero
      endcase
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      RDATA <= '0;
    end else begin
      RDATA <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);

  a_sts_invert_sample: assert property ( // [R01]
    sync_rise |=> sts_q == ~$past(EXTERNAL_STATUS_IN[1:0]))
    else $error("low status bits not inverted sample");

  a_sts_hold_between: assert property ( // [R09]
    !sync_rise |=> $stable(sts_q))
    else $error("low status bits moved without strobe");

  a_sts2_invalid_out: assert property ( // [R10]
    TRANSFER_DIRECTION == SAI_DIR_OUTPUT |=> sts2_q == 1'b0)
    else $error("third status bit live during output");

  a_rcv_enable_dir: assert property ( // [R10]
    $changed(TRANSFER_DIRECTION)
      |=> STS2_RCV_EN == ($past(TRANSFER_DIRECTION) != SAI_DIR_OUTPUT))
    else $error("receiver enable does not follow direction");

  // also covers a clear landing on the edge cycle: the set must win
  a_attention_line_edge_sets: assert property ( // [R03]
    attention_line_edge |=> flag_q)
    else $error("attention edge did not set flag");

  a_flag_read_path: assert property ( // [R03]
    RD && ADDR == SAI_OFS_INT_STAT
      |=> RDATA[SAI_BIT_INT_ATTENTION_LINE] == $past(flag_q))
    else $error("flag not returned on status read");

  a_attention_line_level_ignored: assert property ( // [R05]
    !flag_q && !attention_line_edge |=> !flag_q)
    else $error("flag set without qualifying edge");

  // edge shows three edges after the pins swap, and only once
  a_attention_line_one_request: assert property ( // [R11]
    attention_line_edge |-> ($past(ATTENTION_LINE_P, 3) && !$past(ATTENTION_LINE_N, 3)
      && !$past(ATTENTION_LINE_P, 2) && $past(ATTENTION_LINE_N, 2))
      ##1 !attention_line_edge)
    else $error("one transition flagged twice");

  a_irq_gated_enable: assert property ( // [R04]
    !en_q [*2] |-> !ATTENTION_LINE_IRQ)
    else $error("interrupt raised while forwarding disabled");

  a_irq_follows_flag: assert property ( // [R04]
    flag_q && en_q |=> ATTENTION_LINE_IRQ)
    else $error("enabled flag missed interrupt");

  a_drv_force_test: assert property ( // [R06]
    !TEST_N |=> DATA_DRV_EN)
    else $error("test pin did not force drivers on");

  a_drv_ignores_sts: assert property ( // [R02]
    $changed(EXTERNAL_STATUS_IN) && $stable(TRANSFER_DIRECTION)
      && $stable(TEST_N) |=> $stable(DATA_DRV_EN))
    else $error("driver enable depends on something else");

  a_hood_read_one: assert property ( // [R07]
    !TEST_N ##1 (!TEST_N && RD && ADDR == SAI_OFS_STATUS)
      |=> RDATA[SAI_BIT_HOOD])
    else $error("grounded test pin not read as one");

  c_attention_line_irq: cover property (attention_line_edge && en_q ##2 ATTENTION_LINE_IRQ);
  c_sts_sample: cover property (sync_rise ##1 RD && ADDR == SAI_OFS_STATUS);
  c_clr_race: cover property (attention_line_edge && clr_hit);
  c_hood_loop: cover property (!TEST_N && !TRANSFER_DIRECTION ##1 DATA_DRV_EN);

endmodule // sai_top

//--- verification/sai_peer.sv
// behavioural peripheral driving status, attention and test lines
`timescale 1ns/1ps
module sai_peer (
  input  wire logic       clk,
  input  wire logic       rcv_en,
  output logic      [2:0] sts,
  output logic            attention_line_p,
  output logic            attention_line_n,
  output logic            test_n
);
  logic [2:0] sts_q;
  logic       tgl_q;
  // a disabled receiver shows a changing level, never the last value
  always @(posedge clk) tgl_q <= ~tgl_q;
  assign sts = {rcv_en ? sts_q[2] : tgl_q, sts_q[1:0]};
  // idle line: positive conductor high, negative low
  initial begin
    tgl_q  = 1'b0;
    sts_q  = 3'h0;
    attention_line_p = 1'b1;
    attention_line_n = 1'b0;
    test_n = 1'b1;
  end
  // new status levels, launched just after a clock edge
  task automatic put_sts(input logic [2:0] v);
    @(posedge clk) sts_q <= v;
  endtask
  // both attention conductors move in the same cycle
  task automatic put_attention_line(input logic p, input logic n);
    @(posedge clk) begin
      attention_line_p <= p;
      attention_line_n <= n;
    end
  endtask
  // a fitted test hood grounds the test pin
  task automatic put_hood(input logic on);
    @(posedge clk) test_n <= ~on;
  endtask
endmodule // sai_peer

//--- verification/testbench.sv
// self-checking bench for the status and attention inputs
`timescale 1ns/1ps
module testbench;
  import sai_pkg::*;
  logic                  clk, rst, sync_n, dir, wr, rd;
  logic [SAI_ADDR_W-1:0] addr;
  logic [SAI_DATA_W-1:0] wdata, rdata, got;
  logic [2:0]            sts;
  logic                  ap, an, tn, irq, drv_en, rcv_en;
  int                    n_fail, n_compared, cyc;
  logic                  host_en, host_irq;

  // adapter side passes the card's interrupt on only with its own enable
  assign host_irq = irq & host_en;

  sai_top uut (.CLK_SYS(clk), .RESET(rst), .EXTERNAL_STATUS_IN(sts),
    .ATTENTION_LINE_P(ap), .ATTENTION_LINE_N(an), .TEST_N(tn),
    .SYNC_N(sync_n), .TRANSFER_DIRECTION(dir), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .ATTENTION_LINE_IRQ(irq),
    .DATA_DRV_EN(drv_en), .STS2_RCV_EN(rcv_en));
  sai_peer peer (.clk(clk), .rcv_en(rcv_en), .sts(sts), .attention_line_p(ap),
    .attention_line_n(an), .test_n(tn));

  ////////////////////////////////////////////////////////////////////////
  // common tasks
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic pulse_sync();
    @(posedge clk) sync_n <= 1'b0;
    @(posedge clk) sync_n <= 1'b1;
    wait_n(2);
  endtask
  task automatic summarize();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs();
    rd_reg(SAI_OFS_INT_EN);
    chk("int_en rst", 32'h0, got);
    rd_reg(SAI_OFS_INT_STAT);
    chk("flag rst", 32'h0, got);
    rd_reg(SAI_OFS_INT_CLR);
    chk("clr reads", 32'h0, got);
    rd_reg(8'h10);
    chk("unmapped", 32'h0, got);
  endtask
  // low status bits only move on a sync rise, sense inverted
  task automatic t_status();
    logic [2:0] v;
    logic [1:0] prev;
    peer.put_sts(3'h0);
    pulse_sync();
    prev = 2'h0;
    for (int i = 0; i < 8; i++) begin
      v = 3'(i);
      peer.put_sts(v);
      wait_n(2);
      rd_reg(SAI_OFS_STATUS);
      chk("sts held", {30'h0, ~prev}, 32'(got[1:0]));
      pulse_sync();
      rd_reg(SAI_OFS_STATUS);
      chk("sts low", {30'h0, ~v[1:0]}, 32'(got[1:0]));
      chk("sts2", {31'h0, ~v[2]}, 32'(got[SAI_BIT_STS2]));
      chk("no flag", 32'h0, 32'(got[SAI_BIT_ATTENTION_LINE]));
      chk("drv idle", 32'h0, 32'(drv_en));
      prev = v[1:0];
    end
  endtask
  task automatic t_dir();
    @(posedge clk) dir <= 1'b1;
    wait_n(2);
    chk("rcv out", 32'h0, 32'(rcv_en));
    rd_reg(SAI_OFS_STATUS);
    chk("sts2 out", 32'h0, 32'(got[SAI_BIT_STS2]));
    chk("dir bit", 32'h1, 32'(got[SAI_BIT_DIR]));
    @(posedge clk) dir <= 1'b0;
    wait_n(2);
    chk("rcv in", 32'h1, 32'(rcv_en));
  endtask
  // hood forces the drivers on even while receiving
  task automatic t_hood();
    peer.put_hood(1'b1);
    wait_n(3);
    chk("drv hood", 32'h1, 32'(drv_en));
    rd_reg(SAI_OFS_STATUS);
    chk("hood bit", 32'h1, 32'(got[SAI_BIT_HOOD]));
    peer.put_hood(1'b0);
    wait_n(3);
    chk("drv nohood", 32'h0, 32'(drv_en));
    rd_reg(SAI_OFS_STATUS);
    chk("nohood bit", 32'h0, 32'(got[SAI_BIT_HOOD]));
  endtask
  task automatic t_attention_line();
    peer.put_attention_line(1'b0, 1'b0);
    wait_n(6);
    peer.put_attention_line(1'b0, 1'b1);
    wait_n(6);
    peer.put_attention_line(1'b1, 1'b0);
    wait_n(6);
    rd_reg(SAI_OFS_INT_STAT);
    chk("refused", 32'h0, got);
    peer.put_attention_line(1'b0, 1'b1);
    wait_n(6);
    rd_reg(SAI_OFS_STATUS);
    chk("flag sts", 32'h1, 32'(got[SAI_BIT_ATTENTION_LINE]));
    chk("irq masked", 32'h0, 32'(irq));
    wr_reg(SAI_OFS_INT_CLR, 32'h1);
    wait_n(10);
    rd_reg(SAI_OFS_INT_STAT);
    chk("level only", 32'h0, got);
    peer.put_attention_line(1'b1, 1'b0);
    wr_reg(SAI_OFS_INT_EN, 32'h1);
    rd_reg(SAI_OFS_INT_EN);
    chk("int_en", 32'h1, got);
    chk("irq idle", 32'h0, 32'(irq));
    peer.put_attention_line(1'b0, 1'b1);
    wait_n(6);
    chk("irq fwd", 32'h1, 32'(irq));
    chk("host masked", 32'h0, 32'(host_irq));
    host_en <= 1'b1;
    wait_n(1);
    chk("host fwd", 32'h1, 32'(host_irq));
    wr_reg(SAI_OFS_INT_CLR, 32'h1);
    wait_n(2);
    chk("irq clr", 32'h0, 32'(irq));
    peer.put_attention_line(1'b1, 1'b0);
    wait_n(6);
    // clear strobe lands in the very cycle the edge is seen: set wins
    peer.put_attention_line(1'b0, 1'b1);
    wait_n(1);
    wr_reg(SAI_OFS_INT_CLR, 32'h1);
    rd_reg(SAI_OFS_INT_STAT);
    chk("set wins", 32'h1, got);
    wr_reg(SAI_OFS_INT_CLR, 32'h1);
    peer.put_attention_line(1'b1, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // clock, hang guard and main sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    {n_fail, n_compared, cyc} = '0;
    {rst, sync_n} = 2'h3;
    {dir, wr, rd} = 3'h0;
    host_en = 1'b0;
    addr = '0;
    wdata = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_status();
    t_dir();
    t_hood();
    t_attention_line();
    wait_n(2);
    summarize();
  end
endmodule // testbench
